// ### gpc_pads.sv
// Pad and outside-device model for the port pins.
// Assumes the bench sets ext_en and ext_val for whatever is wired outside the chip.
`timescale 1ns/10ps
module gpc_pads #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pull_up,
  input wire logic [W-1:0] pull_down,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_in
);
  logic [W-1:0] last_q = '0;

  // Resolve each pad: chip driver first, then the outside device, then a weak pull.
  // A pad nobody holds flips every cycle, so a stale level is never taken for a real one.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pull_up[i] | pull_down[i]) begin
        pin_in[i] = pull_up[i];
      end else begin
        pin_in[i] = ~last_q[i];
      end
    end
  end

  // Remember the pad level of the last cycle.
  always_ff @(posedge clk) begin
    last_q <= pin_in;
  end
endmodule : gpc_pads

// ### gpc_pkg.sv
// Shared constants for the general-purpose port with change notice.
// Assumes a 32-bit APB slave; every register owns a 16-byte slot of four aliases.
package gpc_pkg;

  // Default port width and APB address width.
  localparam int GPC_PINS = 16;
  localparam int GPC_AW = 8;

  // Register slot indexes; the byte address of a base register is its index times 16.
  localparam logic [3:0] IDX_ANALOG = 4'h0;
  localparam logic [3:0] IDX_DIR = 4'h1;
  localparam logic [3:0] IDX_LEVEL = 4'h2;
  localparam logic [3:0] IDX_LATCH = 4'h3;
  localparam logic [3:0] IDX_ODC = 4'h4;
  localparam logic [3:0] IDX_PULLUP = 4'h5;
  localparam logic [3:0] IDX_PULLDN = 4'h6;
  localparam logic [3:0] IDX_RISE = 4'h7;
  localparam logic [3:0] IDX_CTRL = 4'h8;
  localparam logic [3:0] IDX_STAT = 4'h9;
  localparam logic [3:0] IDX_FALL = 4'ha;
  localparam logic [3:0] IDX_FLAG = 4'hb;
  localparam logic [3:0] IDX_LAST = 4'hb;

  // Position of the slot index and of the alias selector inside the byte address.
  localparam int ADDR_IDX_LSB = 4;
  localparam int ADDR_OP_LSB = 2;

  // Alias selector: base write, then clear, set and invert at +0x4, +0x8, +0xc.
  typedef enum logic [1:0] {
    GPC_OP_WRITE = 2'h0,
    GPC_OP_CLR = 2'h1,
    GPC_OP_SET = 2'h2,
    GPC_OP_INV = 2'h3
  } gpc_op_t;

  // Change control fields.
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_EDGE_BIT = 11;
  localparam logic [31:0] CTRL_MASK = 32'h00008800;

  // Reset values.
  localparam logic [31:0] ANALOG_RST = 32'h0000ffff;
  localparam logic [31:0] DIR_RST = 32'h0000ffff;
  localparam logic [31:0] ZERO_RST = 32'h00000000;

endpackage : gpc_pkg

// ### gpc_port.sv
// General-purpose I/O port with per-pin direction, latch, open drain, analog select,
// pulls and change notice, reached over an APB slave.
// Assumes CLOCK keeps running while the processor sleeps and pins are asynchronous.
`timescale 1ns/10ps
module gpc_port
  import gpc_pkg::*;
#(
  parameter int W = GPC_PINS
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [GPC_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [W-1:0] PIN_IN,
  output logic [W-1:0] PIN_OUT,
  output logic [W-1:0] PIN_OE,
  output logic [W-1:0] PULL_UP_EN,
  output logic [W-1:0] PULL_DOWN_EN,
  output logic [W-1:0] ANALOG_SEL,
  output logic [W-1:0] ANALOG_LEVEL,
  output logic [W-1:0] PERIPH_IN,
  output logic CHANGE_IRQ
);

  logic [W-1:0] analog_q;
  logic [W-1:0] dir_q;
  logic [W-1:0] latch_q;
  logic [W-1:0] odc_q;
  logic [W-1:0] pullup_q;
  logic [W-1:0] pulldn_q;
  logic [W-1:0] rise_en_q;
  logic [W-1:0] fall_en_q;
  logic [W-1:0] stat_q;
  logic [W-1:0] flag_q;
  logic [W-1:0] ref_q;
  logic [31:0] ctrl_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [W-1:0] pin_s;
  logic [W-1:0] pin_rise;
  logic [W-1:0] pin_fall;
  logic [3:0] idx;
  gpc_op_t op;
  logic mapped;
  logic wr_acc;
  logic setup_rd;
  logic level_take;
  logic on_en;
  logic edge_mode;
  logic [W-1:0] stat_set;
  logic [W-1:0] flag_set;
  logic [W-1:0] level_view;
  logic [31:0] rd_word;

  // Pin inputs are brought into the clock domain first.
  gpc_sync #(.W(W)) u_sync (
    .CLOCK(CLOCK),
    .RSTN(RSTN),
    .pin_raw(PIN_IN),
    .pin_s(pin_s),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Base or alias operation applied to the old register contents.
  function automatic logic [31:0] gpc_apply(input logic [31:0] old, input logic [31:0] wd, input gpc_op_t o);
    logic [31:0] res;
    res = old;
    case (o)
      GPC_OP_WRITE: res = wd;
      GPC_OP_CLR: res = old & ~wd;
      GPC_OP_SET: res = old | wd;
      GPC_OP_INV: res = old ^ wd;
      default: res = old;
    endcase
    return res;
  endfunction : gpc_apply

  // Pin-wide form of the same operation; the upper word bits never reach a pin register.
  function automatic logic [W-1:0] gpc_apply_pin(input logic [W-1:0] old, input logic [W-1:0] wd, input gpc_op_t o);
    logic [31:0] full;
    full = gpc_apply({{(32-W){1'b0}}, old}, {{(32-W){1'b0}}, wd}, o);
    return full[W-1:0];
  endfunction : gpc_apply_pin

  // Address decode: slot index in the upper nibble, alias in bits 3:2.
  assign idx = PADDR[ADDR_IDX_LSB +: 4];
  assign op = gpc_op_t'(PADDR[ADDR_OP_LSB +: 2]);
  assign mapped = (idx <= IDX_LAST);
  assign wr_acc = PSEL & PENABLE & PWRITE & pready_q & mapped;
  assign setup_rd = PSEL & ~PENABLE & ~PWRITE;
  assign level_take = setup_rd & (idx == IDX_LEVEL) & (op == GPC_OP_WRITE);
  assign on_en = ctrl_q[CTRL_ON_BIT];
  assign edge_mode = ctrl_q[CTRL_EDGE_BIT];

  // Analog pins that are inputs read as zero; the read path and PERIPH_IN are cut for them, change notice is not.
  assign level_view = pin_s & ~(analog_q & dir_q);

  // Read data mux; aliases and unmapped slots return zero.
  always_comb begin
    rd_word = ZERO_RST;
    if (op == GPC_OP_WRITE) begin
      case (idx)
        IDX_ANALOG: rd_word[W-1:0] = analog_q;
        IDX_DIR: rd_word[W-1:0] = dir_q;
        IDX_LEVEL: rd_word[W-1:0] = level_view;
        IDX_LATCH: rd_word[W-1:0] = latch_q;
        IDX_ODC: rd_word[W-1:0] = odc_q;
        IDX_PULLUP: rd_word[W-1:0] = pullup_q;
        IDX_PULLDN: rd_word[W-1:0] = pulldn_q;
        IDX_RISE: rd_word[W-1:0] = rise_en_q;
        IDX_CTRL: rd_word = ctrl_q;
        IDX_STAT: rd_word[W-1:0] = stat_q;
        IDX_FALL: rd_word[W-1:0] = fall_en_q;
        IDX_FLAG: rd_word[W-1:0] = flag_q;
        default: rd_word = ZERO_RST;
      endcase
    end
  end

  // The answer is prepared in the setup cycle so every access takes exactly two cycles.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      pready_q <= 1'b0;
      prdata_q <= ZERO_RST;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= PSEL & ~PENABLE & ~pready_q;
      if (PSEL & ~PENABLE) begin
        prdata_q <= PWRITE ? ZERO_RST : rd_word;
        pslverr_q <= ~mapped;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Analog select starts all ones so shared pins come up analog.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      analog_q <= ANALOG_RST[W-1:0];
    end else if (wr_acc && idx == IDX_ANALOG) begin
      analog_q <= gpc_apply_pin(analog_q, PWDATA[W-1:0], op);
    end
  end

  // Direction: every pin is an input out of reset.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      dir_q <= DIR_RST[W-1:0];
    end else if (wr_acc && idx == IDX_DIR) begin
      dir_q <= gpc_apply_pin(dir_q, PWDATA[W-1:0], op);
    end
  end

  // The latch is written from its own slot and from the pin-level slot alike.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      latch_q <= ZERO_RST[W-1:0];
    end else if (wr_acc && (idx == IDX_LATCH || idx == IDX_LEVEL)) begin
      latch_q <= gpc_apply_pin(latch_q, PWDATA[W-1:0], op);
    end
  end

  // Plain configuration registers share one update style.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      odc_q <= ZERO_RST[W-1:0];
      pullup_q <= ZERO_RST[W-1:0];
      pulldn_q <= ZERO_RST[W-1:0];
      rise_en_q <= ZERO_RST[W-1:0];
      fall_en_q <= ZERO_RST[W-1:0];
      ctrl_q <= ZERO_RST;
    end else if (wr_acc) begin
      case (idx)
        IDX_ODC: odc_q <= gpc_apply_pin(odc_q, PWDATA[W-1:0], op);
        IDX_PULLUP: pullup_q <= gpc_apply_pin(pullup_q, PWDATA[W-1:0], op);
        IDX_PULLDN: pulldn_q <= gpc_apply_pin(pulldn_q, PWDATA[W-1:0], op);
        IDX_RISE: rise_en_q <= gpc_apply_pin(rise_en_q, PWDATA[W-1:0], op);
        IDX_FALL: fall_en_q <= gpc_apply_pin(fall_en_q, PWDATA[W-1:0], op);
        IDX_CTRL: ctrl_q <= gpc_apply(ctrl_q, PWDATA, op) & CTRL_MASK;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // A pin-level read takes a new reference at the same edge that samples the read data.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      ref_q <= ZERO_RST[W-1:0];
    end else if (level_take) begin
      ref_q <= pin_s;
    end
  end

  // Mismatch against the reference; during a read the reference takes pin_s, the value returned on all but analog input pins.
  assign stat_set = level_take ? '0 : (rise_en_q & (pin_s ^ ref_q) & {W{on_en & ~edge_mode}});

  // Enabled edges in edge mode; rising and falling are armed separately.
  assign flag_set = (rise_en_q & pin_rise | fall_en_q & pin_fall) & {W{on_en & edge_mode}};

  // Status clears on a pin-level read or a software write; a new mismatch wins over a write, but none is set in the read cycle.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      stat_q <= ZERO_RST[W-1:0];
    end else if (level_take) begin
      stat_q <= stat_set;
    end else if (wr_acc && idx == IDX_STAT) begin
      stat_q <= gpc_apply_pin(stat_q, PWDATA[W-1:0], op) | stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  // Flags are sticky until software clears them; an edge in the clearing cycle survives.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      flag_q <= ZERO_RST[W-1:0];
    end else if (wr_acc && idx == IDX_FLAG) begin
      flag_q <= gpc_apply_pin(flag_q, PWDATA[W-1:0], op) | flag_set;
    end else begin
      flag_q <= flag_q | flag_set;
    end
  end

  // The request runs on the always-on clock, so it wakes a sleeping processor.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      CHANGE_IRQ <= 1'b0;
    end else begin
      CHANGE_IRQ <= on_en & (edge_mode ? |flag_q : |stat_q);
    end
  end

  // Pad controls are registered; open drain turns a high into a release.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      PIN_OUT <= '0;
      PIN_OE <= '0;
      PULL_UP_EN <= '0;
      PULL_DOWN_EN <= '0;
      ANALOG_SEL <= ANALOG_RST[W-1:0];
      ANALOG_LEVEL <= '0;
      PERIPH_IN <= '0;
    end else begin
      PIN_OUT <= latch_q & ~odc_q;
      PIN_OE <= ~dir_q & ~(odc_q & latch_q);
      PULL_UP_EN <= pullup_q;
      PULL_DOWN_EN <= pulldn_q;
      ANALOG_SEL <= analog_q;
      ANALOG_LEVEL <= latch_q & ~dir_q & analog_q;
      PERIPH_IN <= pin_s & ~analog_q;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  // Reset leaves every driver off.
  chk_reset_inputs: assert property (@(posedge CLOCK) !RSTN |=> PIN_OE == '0)
    else $error("pin driver on after reset");

  // An input pin is never driven.
  chk_dir_oe: assert property (@(posedge CLOCK) disable iff (!RSTN) (PIN_OE & $past(dir_q)) == '0)
    else $error("input pin driven");

  // Open-drain pins never drive high.
  chk_odc_high: assert property (@(posedge CLOCK) disable iff (!RSTN) (PIN_OUT & $past(odc_q)) == '0)
    else $error("open-drain pin drove high");

  // Analog inputs read as zero in the pin-level register.
  chk_analog_read: assert property (@(posedge CLOCK) disable iff (!RSTN) level_take |=>
    (PRDATA[W-1:0] & $past(analog_q & dir_q)) == '0)
    else $error("analog pin read nonzero");

  // Alias reads answer zero.
  chk_alias_read: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (setup_rd && op != GPC_OP_WRITE) |=> PRDATA == ZERO_RST)
    else $error("alias read returned data");

  // A set alias on the latch ors the written bits in.
  chk_set_alias: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (wr_acc && idx == IDX_LATCH && op == GPC_OP_SET) |=> latch_q == ($past(latch_q) | $past(PWDATA[W-1:0])))
    else $error("set alias wrong");

  // A clear alias on the flags empties the written bits when no new edge arrives.
  chk_flag_clear: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (wr_acc && idx == IDX_FLAG && op == GPC_OP_CLR && flag_set == '0) |=> (flag_q & $past(PWDATA[W-1:0])) == '0)
    else $error("flag clear alias wrong");

  // A base write to the pin-level slot lands in the latch.
  chk_level_write: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (wr_acc && idx == IDX_LEVEL && op == GPC_OP_WRITE) |=> latch_q == $past(PWDATA[W-1:0]))
    else $error("pin-level write missed latch");

  // A pin-level read refreshes the reference with the sampled pins.
  chk_ref_update: assert property (@(posedge CLOCK) disable iff (!RSTN) level_take |=> ref_q == $past(pin_s))
    else $error("reference not refreshed");

  // An enabled rising edge in edge mode raises a flag and then the request.
  chk_edge_flag: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (on_en && edge_mode && (pin_rise & rise_en_q) != '0) |=> (flag_q != '0) ##1 CHANGE_IRQ)
    else $error("edge flag or request missing");

  // A mismatch in mismatch mode sets status within one cycle.
  chk_mismatch: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (stat_set != '0) |=> ((stat_q & $past(stat_set)) == $past(stat_set)))
    else $error("mismatch status missing");

endmodule : gpc_port

// ### gpc_port_tb.sv
// Self-checking bench for the port: APB register tasks plus pin stimulus.
// Assumes gpc_pkg and the pad model are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gpc_port_tb
  import gpc_pkg::*;
;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [GPC_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [GPC_PINS-1:0] pin_in, pin_out, pin_oe, pu, pd, asel, alvl, pperiph, ext_val, ext_en;
  int errors, n_checks;
  logic [1:0] al_op [3] = '{2'h1, 2'h2, 2'h3};
  logic [31:0] al_d [3] = '{32'h00f0, 32'h000f, 32'hff00};
  logic [31:0] al_e [3] = '{32'ha500, 32'ha50f, 32'h5a0f};

  gpc_port #(.W(GPC_PINS)) gpc_port_i (.CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULL_UP_EN(pu),
    .PULL_DOWN_EN(pd), .ANALOG_SEL(asel), .ANALOG_LEVEL(alvl), .PERIPH_IN(pperiph), .CHANGE_IRQ(irq));

  gpc_pads #(.W(GPC_PINS)) gpc_pads_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pu),
    .pull_down(pd), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Single place where the run ends.
  task automatic wrap_up();
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // One APB transfer; an idle edge first keeps a read clear of the previous write.
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [1:0] op, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, op, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [3:0] idx, input logic [1:0] op, input logic [31:0] d);
    apb(1'b1, idx, op, d);
  endtask : wr

  task automatic rchk(input logic [3:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 2'h0, 32'h0);
    `CHK(rd, e)
  endtask : rchk

  // Wait whole cycles, then step past the edge so its updates have landed.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Outside devices change their levels; leave room for synchroniser, status and request.
  task automatic pins(input logic [15:0] v);
    @(posedge clk);
    ext_val <= v;
    settle(5);
  endtask : pins

  // Main sequence.
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, ext_val, ext_en} = '0;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    `CHK(pin_oe, 16'h0000)
    `CHK(asel, 16'hffff)
    for (int i = 0; i <= 11; i++) begin
      if (i != 2) begin
        rchk(i[3:0], (i < 2) ? 32'h0000ffff : 32'h0);
      end
    end
    wr(4'hc, 2'h0, 32'hffffffff);
    `CHK(err, 1'b1)
    rchk(4'hc, 32'h0);
    wr(IDX_LATCH, GPC_OP_WRITE, 32'hffffa5f0);
    rchk(IDX_LATCH, 32'h0000a5f0);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_LATCH, al_op[k], al_d[k]);
      rchk(IDX_LATCH, al_e[k]);
    end
    apb(1'b0, IDX_LATCH, GPC_OP_SET, 32'h0);
    `CHK(rd, 32'h0)
    // Low byte becomes outputs; three of them open drain.
    wr(IDX_ANALOG, GPC_OP_WRITE, 32'h0);
    wr(IDX_DIR, GPC_OP_CLR, 32'h00ff);
    wr(IDX_ODC, GPC_OP_SET, 32'h0013);
    settle(2);
    `CHK(pin_oe, 16'h00fc)
    `CHK(pin_out & pin_oe, 16'h000c)
    wr(IDX_ODC, GPC_OP_WRITE, 32'h0);
    @(posedge clk);
    ext_en <= 16'hff00;
    ext_val <= 16'hc300;
    settle(4);
    rchk(IDX_LEVEL, 32'h0000c30f);
    wr(IDX_LEVEL, GPC_OP_WRITE, 32'h1234);
    rchk(IDX_LATCH, 32'h00001234);
    // Mixed analog selection.
    wr(IDX_ANALOG, GPC_OP_WRITE, 32'h0f0f);
    settle(2);
    `CHK(alvl, 16'h0004)
    `CHK(asel, 16'h0f0f)
    `CHK(pperiph, 16'hc030)
    rchk(IDX_LEVEL, 32'h0000c034);
    wr(IDX_PULLUP, GPC_OP_WRITE, 32'h00f0);
    wr(IDX_PULLDN, GPC_OP_WRITE, 32'h0f00);
    settle(2);
    `CHK({pu, pd}, 32'h00f00f00)
    // Mismatch mode on pin 8; pin 14 changes too but is not enabled.
    wr(IDX_ANALOG, GPC_OP_WRITE, 32'h0);
    wr(IDX_CTRL, GPC_OP_WRITE, 32'hffffffff);
    rchk(IDX_CTRL, 32'h00008800);
    wr(IDX_CTRL, GPC_OP_WRITE, 32'h8000);
    wr(IDX_RISE, GPC_OP_WRITE, 32'h0100);
    rchk(IDX_LEVEL, 32'h0000c334);
    pins(16'h8200);
    `CHK(irq, 1'b1)
    rchk(IDX_STAT, 32'h0100);
    rchk(IDX_LEVEL, 32'h00008234);
    rchk(IDX_STAT, 32'h0);
    settle(2);
    `CHK(irq, 1'b0)
    // Edge mode: wrong-direction edges first, then the enabled ones.
    wr(IDX_CTRL, GPC_OP_WRITE, 32'h8800);
    wr(IDX_RISE, GPC_OP_WRITE, 32'h0200);
    wr(IDX_FALL, GPC_OP_WRITE, 32'h0400);
    wr(IDX_FLAG, GPC_OP_CLR, 32'hffff);
    pins(16'h8400);
    rchk(IDX_FLAG, 32'h0);
    pins(16'h8200);
    rchk(IDX_FLAG, 32'h0600);
    `CHK(irq, 1'b1)
    wr(IDX_CTRL, GPC_OP_CLR, 32'h8000);
    settle(2);
    `CHK(irq, 1'b0)
    // A reset in mid-run must bring every pin back to input and analog.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    settle(1);
    `CHK(pin_oe, 16'h0000)
    `CHK(asel, 16'hffff)
    rchk(IDX_DIR, 32'h0000ffff);
    wrap_up();
  end
endmodule : gpc_port_tb

// ### gpc_sync.sv
// Two-flop synchroniser for the pin inputs, plus a history stage for edges.
// Assumes pins are asynchronous to CLOCK; only the second stage and the history stage are used downstream.
`timescale 1ns/10ps
module gpc_sync #(
  parameter int W = 16
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_s,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // The first stage feeds only the second, so metastability never leaks out.
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge strobes compare the clean sample with the one before it.
  assign pin_s = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule : gpc_sync
